// ==== design/tcc_pkg.sv ====
// tcc_pkg: shared constants of the 16-bit timer counter with capture
package tcc_pkg;
  // register locations on the 8-bit cpu bus
  localparam logic [3:0] A_CTRL_A = 4'h0;
  localparam logic [3:0] A_CTRL_B = 4'h1;
  localparam logic [3:0] A_CNT_LO = 4'h2;
  localparam logic [3:0] A_CNT_HI = 4'h3;
  localparam logic [3:0] A_CAP_LO = 4'h4;
  localparam logic [3:0] A_CAP_HI = 4'h5;
  localparam logic [3:0] A_CMA_LO = 4'h6;
  localparam logic [3:0] A_CMA_HI = 4'h7;
  localparam logic [3:0] A_CMB_LO = 4'h8;
  localparam logic [3:0] A_CMB_HI = 4'h9;
  localparam logic [3:0] A_MASK   = 4'ha;
  localparam logic [3:0] A_FLAG   = 4'hb;
  //////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CA_WGM_LO = 0;
  localparam int CA_SRC    = 2;
  localparam int CB_CS     = 0;
  localparam int CB_WGM_HI = 3;
  localparam int CB_EDGE   = 6;
  localparam int CB_FILT   = 7;
  localparam int FLG_OVF   = 0;
  localparam int FLG_CAP   = 5;
  //////////////////////////////////////////////////////////////////////
  // reset values and counter constants
  localparam logic [7:0]  ZERO8   = 8'h00;
  localparam logic [15:0] ZERO16  = 16'h0000;
  localparam logic [15:0] ONE16   = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP8    = 16'h00ff;
  localparam logic [15:0] TOP9    = 16'h01ff;
  localparam logic [15:0] TOP10   = 16'h03ff;
  //////////////////////////////////////////////////////////////////////
  // waveform mode tables, one bit per mode code
  localparam logic [15:0] WGM_DUAL    = 16'h0f0e;
  localparam logic [15:0] WGM_CAP_TOP = 16'h5500;
  localparam logic [15:0] WGM_CMP_TOP = 16'h8a10;
  localparam logic [15:0] WGM_CTC     = 16'h1010;
  localparam logic [15:0] WGM_TOP8    = 16'h0022;
  localparam logic [15:0] WGM_TOP9    = 16'h0044;
  localparam logic [15:0] WGM_TOP10   = 16'h0088;
  //////////////////////////////////////////////////////////////////////
  // tick source select codes and prescale masks
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_DIV1  = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K = 3'h5;
  localparam logic [2:0] CS_EXTF  = 3'h6;
  localparam logic [9:0] PM_8     = 10'h007;
  localparam logic [9:0] PM_64    = 10'h03f;
  localparam logic [9:0] PM_256   = 10'h0ff;
  localparam logic [9:0] PM_1K    = 10'h3ff;
  localparam logic [9:0] PRE_ONE  = 10'h001;
  localparam logic [9:0] PRE_ZERO = 10'h000;
  // count direction
  typedef enum logic {TCC_UP = 1'b0, TCC_DOWN = 1'b1} tcc_dir_t;
endpackage : tcc_pkg

// ==== design/tcc_tick.sv ====
// tcc_tick: tick source selection, prescaler and external pin sampling
`timescale 1ns/1ps
module tcc_tick (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // select and pin
  input  wire logic [2:0] cs,
  input  wire logic       ext_tick_pin,
  // tick out
  output logic            tick
);
  logic [9:0] pre_q, pre_d;
  logic       s1_q, s2_q, s3_q, st_q, st_d, pv_q;

  always_comb begin
    pre_d = pre_q + tcc_pkg::PRE_ONE;
    st_d  = (s2_q == s3_q) ? s3_q : st_q;
    tick  = 1'b0;
    case (cs)
      tcc_pkg::CS_STOP:   tick = 1'b0;
      tcc_pkg::CS_DIV1:   tick = 1'b1;
      tcc_pkg::CS_DIV8:   tick = (pre_q & tcc_pkg::PM_8) == tcc_pkg::PM_8;
      tcc_pkg::CS_DIV64:  tick = (pre_q & tcc_pkg::PM_64) == tcc_pkg::PM_64;
      tcc_pkg::CS_DIV256: tick = (pre_q & tcc_pkg::PM_256) == tcc_pkg::PM_256;
      tcc_pkg::CS_DIV1K:  tick = pre_q == tcc_pkg::PM_1K;
      tcc_pkg::CS_EXTF:   tick = pv_q & ~st_q;
      default:            tick = ~pv_q & st_q;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= tcc_pkg::PRE_ZERO;
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      st_q  <= 1'b0;
      pv_q  <= 1'b0;
    end else if (ce) begin
      pre_q <= pre_d;
      s1_q  <= ext_tick_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      st_q  <= st_d;
      pv_q  <= st_q;
    end
  end

  a_stopped_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    cs == tcc_pkg::CS_STOP |-> !tick)
    else $error("tick while no source selected");
endmodule : tcc_tick

// ==== design/tcc_capin.sv ====
// tcc_capin: capture source select, sampling, noise filter, edge detect
`timescale 1ns/1ps
module tcc_capin #(
  parameter int FILT_LEN = 4
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ce,
  // capture sources
  input  wire logic capture_input_pin,
  input  wire logic comparator_output,
  // controls
  input  wire logic src_comp,
  input  wire logic filt_en,
  input  wire logic edge_rise,
  input  wire logic enable,
  // event out
  output logic      cap_evt
);
  logic                s1_q, s2_q, s3_q, st_q, st_d;
  logic [FILT_LEN-2:0] hist_q, hist_d;
  logic [FILT_LEN-1:0] win;
  logic                flt_q, flt_d, pv_q, cur;

  always_comb begin
    st_d   = (s2_q == s3_q) ? s3_q : st_q;
    win    = {hist_q, st_q};
    hist_d = win[FILT_LEN-2:0];
    flt_d  = flt_q;
    if (&win) flt_d = 1'b1;
    else if (~|win) flt_d = 1'b0;
    cur     = filt_en ? flt_q : st_q;
    cap_evt = enable & (edge_rise ? (cur & ~pv_q) : (~cur & pv_q));
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      st_q   <= 1'b0;
      hist_q <= '0;
      flt_q  <= 1'b0;
      pv_q   <= 1'b0;
    end else if (ce) begin
      s1_q   <= src_comp ? comparator_output : capture_input_pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      st_q   <= st_d;
      hist_q <= hist_d;
      flt_q  <= flt_d;
      pv_q   <= cur;
    end
  end

  a_filter_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && (|win) && !(&win) |=> flt_q == $past(flt_q))
    else $error("filter output moved on mixed samples");
endmodule : tcc_capin

// ==== design/tcc_core.sv ====
// tcc_core: 16-bit timer counter, capture register and byte latch
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module tcc_core (
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // cpu byte bus
  input  wire logic [3:0]  cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  // external inputs
  input  wire logic        ext_tick_pin,
  input  wire logic        capture_input_pin,
  input  wire logic        comparator_output,
  // interrupt requests and acknowledges
  input  wire logic        irq_ack_ovf,
  input  wire logic        irq_ack_cap,
  output logic             irq_overflow,
  output logic             irq_capture,
  // counter status
  output logic      [15:0] timer_count,
  output logic             count_top_mark,
  output logic             count_zero_mark
);
  logic [7:0]  ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d;
  logic [7:0]  mask_q, mask_d, latch_q, latch_d, rdata_q, rdata_d;
  logic [15:0] cnt_q, cnt_d, cap_q, cap_d;
  logic [15:0] cma_q, cma_d, cmb_q, cmb_d, top;
  logic        ovf_q, ovf_d, capf_q, capf_d, ovf_evt;
  tcc_pkg::tcc_dir_t dir_q, dir_d;
  logic [3:0]  waveform_mode;
  logic [2:0]  cs;
  logic        tick, cap_evt, dual, ctc, cap_top;
  logic        wr_cl, wr_ch, wr_pl, wr_ph, wr_al, wr_ah, wr_bl, wr_bh;
  logic        rd_cl, rd_pl, wr_fl;

  //////////////////////////////////////////////////////////////////////
  // decode of controls
  assign waveform_mode = {ctrl_b_q[tcc_pkg::CB_WGM_HI +: 2],
                          ctrl_a_q[tcc_pkg::CA_WGM_LO +: 2]};
  assign cs      = ctrl_b_q[tcc_pkg::CB_CS +: 3];
  assign dual    = tcc_pkg::WGM_DUAL[waveform_mode];
  assign ctc     = tcc_pkg::WGM_CTC[waveform_mode];
  assign cap_top = tcc_pkg::WGM_CAP_TOP[waveform_mode];

  always_comb begin
    if (cap_top) begin
      top = cap_q;
    end else if (tcc_pkg::WGM_CMP_TOP[waveform_mode]) begin
      top = cma_q;
    end else if (tcc_pkg::WGM_TOP8[waveform_mode]) begin
      top = tcc_pkg::TOP8;
    end else if (tcc_pkg::WGM_TOP9[waveform_mode]) begin
      top = tcc_pkg::TOP9;
    end else if (tcc_pkg::WGM_TOP10[waveform_mode]) begin
      top = tcc_pkg::TOP10;
    end else begin
      top = tcc_pkg::CNT_MAX;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bus strobes
  assign wr_cl = cpu_wr && cpu_addr == tcc_pkg::A_CNT_LO;
  assign wr_ch = cpu_wr && cpu_addr == tcc_pkg::A_CNT_HI;
  assign wr_pl = cpu_wr && cpu_addr == tcc_pkg::A_CAP_LO;
  assign wr_ph = cpu_wr && cpu_addr == tcc_pkg::A_CAP_HI;
  assign wr_al = cpu_wr && cpu_addr == tcc_pkg::A_CMA_LO;
  assign wr_ah = cpu_wr && cpu_addr == tcc_pkg::A_CMA_HI;
  assign wr_bl = cpu_wr && cpu_addr == tcc_pkg::A_CMB_LO;
  assign wr_bh = cpu_wr && cpu_addr == tcc_pkg::A_CMB_HI;
  assign wr_fl = cpu_wr && cpu_addr == tcc_pkg::A_FLAG;
  assign rd_cl = cpu_rd && cpu_addr == tcc_pkg::A_CNT_LO;
  assign rd_pl = cpu_rd && cpu_addr == tcc_pkg::A_CAP_LO;

  //////////////////////////////////////////////////////////////////////
  // tick source and capture input
  tcc_tick u_tick (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .ce           (ce),
    .cs           (cs),
    .ext_tick_pin (ext_tick_pin),
    .tick         (tick)
  );

  tcc_capin #(.FILT_LEN(4)) u_capin (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .ce                (ce),
    .capture_input_pin (capture_input_pin),
    .comparator_output (comparator_output),
    .src_comp          (ctrl_a_q[tcc_pkg::CA_SRC]),
    .filt_en           (ctrl_b_q[tcc_pkg::CB_FILT]),
    .edge_rise         (ctrl_b_q[tcc_pkg::CB_EDGE]),
    .enable            (~cap_top),
    .cap_evt           (cap_evt)
  );

  //////////////////////////////////////////////////////////////////////
  // counter unit
  always_comb begin
    cnt_d   = cnt_q;
    dir_d   = dir_q;
    ovf_evt = 1'b0;
    if (tick) begin
      if (dual) begin
        if (dir_q == tcc_pkg::TCC_UP) begin
          if (cnt_q == top) begin
            dir_d = tcc_pkg::TCC_DOWN;
            cnt_d = cnt_q - tcc_pkg::ONE16;
          end else begin
            cnt_d = cnt_q + tcc_pkg::ONE16;
          end
        end else if (cnt_q == tcc_pkg::ZERO16) begin
          dir_d   = tcc_pkg::TCC_UP;
          cnt_d   = cnt_q + tcc_pkg::ONE16;
          ovf_evt = 1'b1;
        end else begin
          cnt_d = cnt_q - tcc_pkg::ONE16;
        end
      end else begin
        dir_d   = tcc_pkg::TCC_UP;
        ovf_evt = ctc ? (cnt_q == tcc_pkg::CNT_MAX)
                      : (cnt_q == top);
        if (cnt_q == top) begin
          cnt_d = tcc_pkg::ZERO16;
        end else begin
          cnt_d = cnt_q + tcc_pkg::ONE16;
        end
      end
    end
    if (wr_cl) begin
      cnt_d = {latch_q, cpu_wdata};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= tcc_pkg::ZERO16;
      dir_q <= tcc_pkg::TCC_UP;
    end else if (ce) begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  assign timer_count     = cnt_q;
  assign count_top_mark  = cnt_q == top;
  assign count_zero_mark = cnt_q == tcc_pkg::ZERO16;

  //////////////////////////////////////////////////////////////////////
  // capture register and flags
  always_comb begin
    cap_d  = cap_q;
    capf_d = capf_q;
    ovf_d  = ovf_q;
    if (wr_pl && cap_top) begin
      cap_d = {latch_q, cpu_wdata};
    end
    if (cap_evt) begin
      cap_d = cnt_q;
    end
    if (irq_ack_cap || (wr_fl && cpu_wdata[tcc_pkg::FLG_CAP])) begin
      capf_d = 1'b0;
    end
    if (cap_evt) begin
      capf_d = 1'b1;
    end
    if (irq_ack_ovf || (wr_fl && cpu_wdata[tcc_pkg::FLG_OVF])) begin
      ovf_d = 1'b0;
    end
    if (ovf_evt) begin
      ovf_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cap_q  <= tcc_pkg::ZERO16;
      capf_q <= 1'b0;
      ovf_q  <= 1'b0;
    end else if (ce) begin
      cap_q  <= cap_d;
      capf_q <= capf_d;
      ovf_q  <= ovf_d;
    end
  end

  assign irq_capture  = capf_q & mask_q[tcc_pkg::FLG_CAP];
  assign irq_overflow = ovf_q & mask_q[tcc_pkg::FLG_OVF];

  //////////////////////////////////////////////////////////////////////
  // control, compare, latch and read data
  always_comb begin
    logic [7:0] flags;
    flags = tcc_pkg::ZERO8;
    flags[tcc_pkg::FLG_OVF] = ovf_q;
    flags[tcc_pkg::FLG_CAP] = capf_q;
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    mask_d   = mask_q;
    cma_d    = cma_q;
    cmb_d    = cmb_q;
    latch_d  = latch_q;
    rdata_d  = rdata_q;
    if (cpu_wr && cpu_addr == tcc_pkg::A_CTRL_A) ctrl_a_d = cpu_wdata;
    if (cpu_wr && cpu_addr == tcc_pkg::A_CTRL_B) ctrl_b_d = cpu_wdata;
    if (cpu_wr && cpu_addr == tcc_pkg::A_MASK) mask_d = cpu_wdata;
    if (wr_ch || wr_ph || wr_ah || wr_bh) begin
      latch_d = cpu_wdata;
    end
    if (wr_al) cma_d = {latch_q, cpu_wdata};
    if (wr_bl) cmb_d = {latch_q, cpu_wdata};
    if (rd_cl) begin
      latch_d = cnt_q[15:8];
    end else if (rd_pl) begin
      latch_d = cap_q[15:8];
    end
    if (cpu_rd) begin
      if (cpu_addr == tcc_pkg::A_CTRL_A) begin
        rdata_d = ctrl_a_q;
      end else if (cpu_addr == tcc_pkg::A_CTRL_B) begin
        rdata_d = ctrl_b_q;
      end else if (cpu_addr == tcc_pkg::A_CNT_LO) begin
        rdata_d = cnt_q[7:0];
      end else if (cpu_addr == tcc_pkg::A_CAP_LO) begin
        rdata_d = cap_q[7:0];
      end else if (cpu_addr == tcc_pkg::A_CNT_HI ||
                   cpu_addr == tcc_pkg::A_CAP_HI) begin
        rdata_d = latch_q;
      end else if (cpu_addr == tcc_pkg::A_CMA_LO) begin
        rdata_d = cma_q[7:0];
      end else if (cpu_addr == tcc_pkg::A_CMA_HI) begin
        rdata_d = cma_q[15:8];
      end else if (cpu_addr == tcc_pkg::A_CMB_LO) begin
        rdata_d = cmb_q[7:0];
      end else if (cpu_addr == tcc_pkg::A_CMB_HI) begin
        rdata_d = cmb_q[15:8];
      end else if (cpu_addr == tcc_pkg::A_MASK) begin
        rdata_d = mask_q;
      end else if (cpu_addr == tcc_pkg::A_FLAG) begin
        rdata_d = flags;
      end else begin
        rdata_d = tcc_pkg::ZERO8;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_a_q <= tcc_pkg::ZERO8;
      ctrl_b_q <= tcc_pkg::ZERO8;
      mask_q   <= tcc_pkg::ZERO8;
      cma_q    <= tcc_pkg::ZERO16;
      cmb_q    <= tcc_pkg::ZERO16;
      latch_q  <= tcc_pkg::ZERO8;
      rdata_q  <= tcc_pkg::ZERO8;
    end else if (ce) begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      mask_q   <= mask_d;
      cma_q    <= cma_d;
      cmb_q    <= cmb_d;
      latch_q  <= latch_d;
      rdata_q  <= rdata_d;
    end
  end

  assign cpu_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_stop_holds: assert property (
    ce && cs == tcc_pkg::CS_STOP && !wr_cl |=> $stable(cnt_q))
    else $error("counter moved with no tick source");

  a_write_wins: assert property (
    ce && wr_cl |=> cnt_q == {$past(latch_q), $past(cpu_wdata)})
    else $error("counter write lost");

  a_count_step: assert property (
    ce && tick && !wr_cl && cnt_q != top && cnt_q != tcc_pkg::ZERO16
    |=> (cnt_q == $past(cnt_q) + tcc_pkg::ONE16) ||
        (cnt_q == $past(cnt_q) - tcc_pkg::ONE16))
    else $error("counter step not one");

  a_capture_copy: assert property (
    ce && cap_evt |=> cap_q == $past(cnt_q) && capf_q)
    else $error("capture value or flag wrong");

  a_latch_load: assert property (
    ce && rd_cl ##1 ce && cpu_rd && cpu_addr == tcc_pkg::A_CNT_HI
    |=> cpu_rdata == $past(cnt_q[15:8], 2))
    else $error("high byte not from latch");

  a_cmp_direct: assert property (
    ce && cpu_rd && cpu_addr == tcc_pkg::A_CMA_HI && !cpu_wr
    |=> cpu_rdata == $past(cma_q[15:8]) && $stable(latch_q))
    else $error("compare read touched latch");

  a_cap_locked: assert property (
    ce && !cap_top && !cap_evt |=> $stable(cap_q))
    else $error("capture written outside capture-top mode");

  a_flag_irq: assert property (
    ce && cap_evt && mask_q[tcc_pkg::FLG_CAP] &&
    !(cpu_wr && cpu_addr == tcc_pkg::A_MASK) |=> irq_capture)
    else $error("capture irq missing");

  a_ovf_clear: assert property (
    ce && irq_ack_ovf && !ovf_evt |=> !ovf_q)
    else $error("overflow flag not cleared");
endmodule : tcc_core

// ==== test/tcc_far_model.sv ====
// tcc_far_model: capture sources on the far side, with a settable delay
`timescale 1ns/1ps
module tcc_far_model #(
  parameter int DLY = 3
) (
  // clock
  input  wire logic mclk,
  // levels asked for by the bench
  input  wire logic pin_lvl,
  input  wire logic cmp_lvl,
  // lines toward the core
  output logic      capture_input_pin,
  output logic      comparator_output
);
  logic [DLY-1:0] pin_sr;
  logic [DLY-1:0] cmp_sr;
  initial begin
    pin_sr = '0;
    cmp_sr = '1;
  end
  // each source follows its request DLY cycles late
  always @(posedge mclk) begin
    pin_sr <= {pin_sr[DLY-2:0], pin_lvl};
    cmp_sr <= {cmp_sr[DLY-2:0], cmp_lvl};
  end
  assign capture_input_pin = pin_sr[DLY-1];
  assign comparator_output = cmp_sr[DLY-1];
endmodule : tcc_far_model

// ==== test/tb_top.sv ====
// tb_top: self-checking bench of the timer counter core
`timescale 1ns/1ps
module tb_top;
  logic        mclk, rst_b, ce, cpu_wr, cpu_rd, ext_tick_pin;
  logic [3:0]  cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, b;
  logic        capture_input_pin, comparator_output, pin_lvl, cmp_lvl;
  logic        irq_ack_ovf, irq_ack_cap, irq_overflow, irq_capture;
  logic [15:0] timer_count, w, a;
  logic        count_top_mark, count_zero_mark;
  int          err_total, num_checks, cyc, n, n0;
  //////////////////////////////////////////////////////////////////////
  tcc_core tcc_core_i (.mclk(mclk), .rst_b(rst_b), .ce(ce),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .ext_tick_pin(ext_tick_pin), .capture_input_pin(capture_input_pin),
    .comparator_output(comparator_output), .irq_ack_ovf(irq_ack_ovf),
    .irq_ack_cap(irq_ack_cap), .irq_overflow(irq_overflow),
    .irq_capture(irq_capture), .timer_count(timer_count),
    .count_top_mark(count_top_mark), .count_zero_mark(count_zero_mark));
  tcc_far_model tcc_far_model_i (.mclk(mclk), .pin_lvl(pin_lvl),
    .cmp_lvl(cmp_lvl), .capture_input_pin(capture_input_pin),
    .comparator_output(comparator_output));
  //////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: flag %b want %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr  <= ad;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge mclk);
    cpu_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge mclk);
    cpu_addr <= ad;
    cpu_rd   <= 1'b1;
    @(posedge mclk);
    cpu_rd   <= 1'b0;
    #1 d = cpu_rdata;
  endtask : rd
  // high byte first; no handler shares the latch here
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask : rd16
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk16(timer_count, 16'h0000);
    chk1(count_zero_mark, 1'b1);
    chk1(count_top_mark, 1'b0);
  endtask : t_reset
  task automatic t_access();
    wr16(tcc_pkg::A_CNT_LO, 16'h01ff);
    #1 chk16(timer_count, 16'h01ff);
    tick(20);
    chk16(timer_count, 16'h01ff);
    rd16(tcc_pkg::A_CNT_LO, w);
    chk16(w, 16'h01ff);
    wr(tcc_pkg::A_CNT_HI, 8'h77);
    #1 chk16(timer_count, 16'h01ff);
    rd(tcc_pkg::A_CNT_HI, b);
    chk16({8'h00, b}, 16'h0077);
  endtask : t_access
  task automatic t_count();
    wr(tcc_pkg::A_CTRL_B, 8'h01);
    tick(4);
    a = timer_count;
    tick(1);
    chk16(timer_count, a + 16'h0001);
    wr16(tcc_pkg::A_CNT_LO, 16'h1234);
    #1 chk16(timer_count, 16'h1234);
    wr(tcc_pkg::A_CTRL_A, 8'h01);
    wr16(tcc_pkg::A_CNT_LO, 16'h00fe);
    n = 0;
    while (count_top_mark !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk16(timer_count, 16'h00ff);
    tick(1);
    chk16(timer_count, 16'h00fe);
    wr(tcc_pkg::A_CTRL_B, 8'h00);
    wr(tcc_pkg::A_CTRL_A, 8'h00);
  endtask : t_count
  task automatic t_ovf();
    wr16(tcc_pkg::A_CNT_LO, 16'hfff0);
    wr(tcc_pkg::A_FLAG, 8'h21);
    wr(tcc_pkg::A_MASK, 8'h21);
    #1 chk1(irq_overflow, 1'b0);
    wr(tcc_pkg::A_CTRL_B, 8'h01);
    n = 0;
    while (count_top_mark !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    chk16(timer_count, 16'hffff);
    tick(3);
    chk1(irq_overflow, 1'b1);
    wr(tcc_pkg::A_CTRL_B, 8'h00);
    irq_ack_ovf <= 1'b1;
    @(posedge mclk);
    irq_ack_ovf <= 1'b0;
    tick(1);
    chk1(irq_overflow, 1'b0);
  endtask : t_ovf
  // one capture from the chosen source; n gets the latency
  task automatic t_cap(input logic comp, input logic rise, input logic filt);
    wr(tcc_pkg::A_CTRL_B, {filt, rise, 6'h00});
    wr(tcc_pkg::A_CTRL_A, {5'h00, comp, 2'b00});
    pin_lvl <= ~rise;
    cmp_lvl <= ~rise;
    tick(20);
    wr(tcc_pkg::A_FLAG, 8'h20);
    #1 chk1(irq_capture, 1'b0);
    if (comp) cmp_lvl <= rise;
    else pin_lvl <= rise;
    n = 0;
    while (irq_capture !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk1(irq_capture, 1'b1);
    rd16(tcc_pkg::A_CAP_LO, w);
    chk16(w, 16'h4321);
  endtask : t_cap
  task automatic t_capture();
    wr16(tcc_pkg::A_CNT_LO, 16'h4321);
    t_cap(1'b0, 1'b1, 1'b0);
    n0 = n;
    t_cap(1'b0, 1'b1, 1'b1);
    chk16(16'(n - n0), 16'h0004);
    t_cap(1'b1, 1'b0, 1'b0);
    irq_ack_cap <= 1'b1;
    @(posedge mclk);
    irq_ack_cap <= 1'b0;
    tick(1);
    chk1(irq_capture, 1'b0);
  endtask : t_capture
  task automatic t_regs();
    wr16(tcc_pkg::A_CAP_LO, 16'hbeef);
    rd16(tcc_pkg::A_CAP_LO, w);
    chk16(w, 16'h4321);
    wr(tcc_pkg::A_CTRL_B, 8'h18);
    wr16(tcc_pkg::A_CAP_LO, 16'habcd);
    rd16(tcc_pkg::A_CAP_LO, w);
    chk16(w, 16'habcd);
    wr16(tcc_pkg::A_CMA_LO, 16'h5a6b);
    rd(tcc_pkg::A_CNT_LO, b);
    rd16(tcc_pkg::A_CMA_LO, w);
    chk16(w, 16'h5a6b);
    rd(tcc_pkg::A_CNT_HI, b);
    chk16({8'h00, b}, 16'h0043);
    rd(4'hc, b);
    chk16({8'h00, b}, 16'h0000);
  endtask : t_regs
  // prescaled tick, then external falling and rising edge ticks
  task automatic t_ext();
    wr(tcc_pkg::A_CTRL_B, 8'h02);
    #1 a = timer_count;
    tick(64);
    chk16(timer_count, a + 16'h0008);
    for (int k = 6; k < 8; k++) begin
      wr(tcc_pkg::A_CTRL_B, 8'(k));
      #1 a = timer_count;
      repeat (3) begin
        ext_tick_pin <= 1'b1;
        tick(8);
        ext_tick_pin <= 1'b0;
        tick(8);
      end
      chk16(timer_count, a + 16'h0003);
    end
    wr(tcc_pkg::A_CTRL_B, 8'h00);
    #1 a = timer_count;
    tick(10);
    chk16(timer_count, a);
  endtask : t_ext
  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    {rst_b, cpu_wr, cpu_rd, ext_tick_pin, irq_ack_ovf, irq_ack_cap} = '0;
    {ce, cmp_lvl} = 2'b11;
    {cpu_addr, cpu_wdata, pin_lvl} = '0;
    {err_total, num_checks, cyc} = '0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    #1 t_reset();
    t_access();
    t_count();
    t_ovf();
    t_capture();
    t_regs();
    t_ext();
    give_verdict();
  end
endmodule : tb_top
